// file: rtl/mscr_top.sv
// mscr_top: miscellaneous control registers behind an apb slave
// assumes: one pclk domain; pins asynchronous; oscillator clocks as sampled inputs
//
// Behaviour
// - a two-bit sense code means 00 fall plus low level, 01 fall, 10 rise, 11 both edges.
// - group one sense code governs port A low nibble, port B and port D interrupt lines.
// - group one sense bits change only while the cpu priority bits are 11.
// - group two sense code in bits 5:4 governs port A high nibble and port C.
// - both group sense codes, group two included, change only at priority level 3; the nmi bits change at any level.
// - bits 3 and 2 of both control registers read as zero.
// - nmi uses the falling edge when the edge bit is 0, rising when 1; it changes only while disabled.
// - nmi pin raises an interrupt only while its enable bit is 1.
// - the aux clock-out bit puts the 32 kHz clock halved on its pin, else the pin is plain io.
// - beep code 000 io, 100 oscillator halved, x01/x10/x11 about 2 kHz, 1 kHz, 500 Hz.
// - clock-out and beep stop in any halt mode.
// - slave-select source bit picks the external pin or the soft value bit for the spi.
// - both control registers clear to zero at reset.
`default_nettype none

module mscr_top (
	// clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pce,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// cpu state
	input wire logic [1:0] cpu_priority,
	input wire logic halt_mode,
	// external interrupt pins
	input wire logic ext_irq_porta_low,
	input wire logic ext_irq_porta_high,
	input wire logic ext_irq_portb,
	input wire logic ext_irq_portc,
	input wire logic ext_irq_portd,
	input wire logic nmi_pin,
	// clock sources, sampled
	input wire logic osc_clk,
	input wire logic aux32k_clk,
	// pin functions
	output logic beep_pin,
	output logic beep_pin_alt,
	output logic aux_clock_pin,
	output logic aux_clock_pin_alt,
	// spi slave select
	input wire logic ss_pin_n,
	output logic spi_ss_n,
	// interrupts
	output logic [4:0] ext_irq_req,
	output logic nmi_req,
	output logic irq
);
	import mscr_pkg::*;

	// ==========================================================
	// apb decode
	logic wr_acc, rd_acc, hit;
	assign wr_acc = psel & penable & pwrite & pce;
	assign rd_acc = psel & ~pwrite & pce;
	assign hit = paddr == MSCR_OFS_SENSE || paddr == MSCR_OFS_PINFN ||
		paddr == MSCR_OFS_IRQ_STAT || paddr == MSCR_OFS_IRQ_MASK;

	// ==========================================================
	// control registers
	logic [7:0] sense_r, sense_nxt, pinfn_r, pinfn_nxt;
	logic [2:0] stat_r, stat_nxt, mask_r, mask_nxt;
	logic [2:0] evt;
	logic lvl3;
	assign lvl3 = cpu_priority == MSCR_PRIO_LEVEL3;

	always_comb begin
		sense_nxt = sense_r;
		pinfn_nxt = pinfn_r;
		mask_nxt = mask_r;
		stat_nxt = stat_r;
		if (wr_acc && paddr == MSCR_OFS_SENSE) begin
			if (lvl3) begin
				sense_nxt[MSCR_G1_HI:MSCR_G1_LO] = pwdata[MSCR_G1_HI:MSCR_G1_LO];
				sense_nxt[MSCR_G2_HI:MSCR_G2_LO] = pwdata[MSCR_G2_HI:MSCR_G2_LO];
			end
			if (!sense_r[MSCR_NMI_EN])
				sense_nxt[MSCR_NMI_EDGE] = pwdata[MSCR_NMI_EDGE];
			sense_nxt[MSCR_NMI_EN] = pwdata[MSCR_NMI_EN];
		end
		if (wr_acc && paddr == MSCR_OFS_PINFN)
			pinfn_nxt = pwdata[7:0] & MSCR_RSVD_MASK;
		if (wr_acc && paddr == MSCR_OFS_IRQ_MASK)
			mask_nxt = pwdata[MSCR_NIRQ-1:0];
		if (wr_acc && paddr == MSCR_OFS_IRQ_STAT)
			stat_nxt = stat_r & ~pwdata[MSCR_NIRQ-1:0];
		stat_nxt = stat_nxt | evt; // set wins over clear
	end

	// ==========================================================
	// event detection, one detector per pin
	logic [4:0] pin_evt;
	logic [4:0] pins;
	logic [1:0] grp_sense [5];
	logic nmi_evt;
	assign pins = {ext_irq_portd, ext_irq_portc, ext_irq_portb, ext_irq_porta_high, ext_irq_porta_low};
	assign grp_sense[0] = sense_r[MSCR_G1_HI:MSCR_G1_LO];
	assign grp_sense[1] = sense_r[MSCR_G2_HI:MSCR_G2_LO];
	assign grp_sense[2] = sense_r[MSCR_G1_HI:MSCR_G1_LO];
	assign grp_sense[3] = sense_r[MSCR_G2_HI:MSCR_G2_LO];
	assign grp_sense[4] = sense_r[MSCR_G1_HI:MSCR_G1_LO];

	for (genvar i = 0; i < 5; i++) begin : g_det
		mscr_edge u_det (
			.pclk(pclk),
			.presetn(presetn),
			.pce(pce),
			.pin(pins[i]),
			.sense(grp_sense[i]),
			.event_o(pin_evt[i])
		);
	end

	// nmi: code 01 falling, 10 rising
	mscr_edge u_nmi (
		.pclk(pclk),
		.presetn(presetn),
		.pce(pce),
		.pin(nmi_pin),
		.sense(sense_r[MSCR_NMI_EDGE] ? 2'h2 : 2'h1),
		.event_o(nmi_evt)
	);

	assign evt[MSCR_IRQ_G1] = pin_evt[0] | pin_evt[2] | pin_evt[4];
	assign evt[MSCR_IRQ_G2] = pin_evt[1] | pin_evt[3];
	assign evt[MSCR_IRQ_NMI] = nmi_evt & sense_r[MSCR_NMI_EN];

	// ==========================================================
	// clock sources: two-flop sync, then edge detect
	logic osc1_r, osc2_r, osc3_r, aux1_r, aux2_r, aux3_r;
	logic ss1_r, ss2_r;
	logic [13:0] bcnt_r, bcnt_nxt, half;
	logic btog_r, btog_nxt, otog_r, otog_nxt, atog_r, atog_nxt;
	logic osc_rise, aux_rise;
	assign osc_rise = osc2_r & ~osc3_r;
	assign aux_rise = aux2_r & ~aux3_r;

	always_comb begin
		case (pinfn_r[MSCR_BEEP_HI:MSCR_BEEP_LO])
			2'h1: half = MSCR_HALF_2K;
			2'h2: half = MSCR_HALF_1K;
			default: half = MSCR_HALF_500;
		endcase
		bcnt_nxt = bcnt_r;
		btog_nxt = btog_r;
		otog_nxt = otog_r;
		atog_nxt = atog_r;
		if (halt_mode) begin
			bcnt_nxt = 14'h0000;
			btog_nxt = 1'b0;
			otog_nxt = 1'b0;
			atog_nxt = 1'b0;
		end else begin
			if (osc_rise) begin
				otog_nxt = ~otog_r;
				if (bcnt_r >= half - 14'h0001) begin
					bcnt_nxt = 14'h0000;
					btog_nxt = ~btog_r;
				end else
					bcnt_nxt = bcnt_r + 14'h0001;
			end
			if (aux_rise)
				atog_nxt = ~atog_r;
		end
	end

	// ==========================================================
	// pin output selection
	logic beep_nxt, beep_alt_nxt, aux_nxt, aux_alt_nxt;
	always_comb begin
		beep_alt_nxt = 1'b0;
		beep_nxt = 1'b0;
		if (!halt_mode) begin
			if (pinfn_r[MSCR_BEEP_HI:MSCR_BEEP_LO] != 2'h0) begin
				beep_alt_nxt = 1'b1;
				beep_nxt = btog_r;
			end else if (pinfn_r[MSCR_MAIN_CO]) begin
				beep_alt_nxt = 1'b1;
				beep_nxt = otog_r;
			end
		end
		aux_alt_nxt = pinfn_r[MSCR_AUX_CO] & ~halt_mode;
		aux_nxt = aux_alt_nxt & atog_r;
	end

	// ==========================================================
	// registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sense_r <= MSCR_RST_SENSE;
			pinfn_r <= MSCR_RST_PINFN;
			stat_r <= 3'h0;
			mask_r <= 3'h0;
			osc1_r <= 1'b0;
			osc2_r <= 1'b0;
			osc3_r <= 1'b0;
			aux1_r <= 1'b0;
			aux2_r <= 1'b0;
			aux3_r <= 1'b0;
			ss1_r <= 1'b1;
			ss2_r <= 1'b1;
			bcnt_r <= 14'h0000;
			btog_r <= 1'b0;
			otog_r <= 1'b0;
			atog_r <= 1'b0;
			beep_pin <= 1'b0;
			beep_pin_alt <= 1'b0;
			aux_clock_pin <= 1'b0;
			aux_clock_pin_alt <= 1'b0;
			spi_ss_n <= 1'b1;
			ext_irq_req <= 5'h00;
			nmi_req <= 1'b0;
			irq <= 1'b0;
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (pce) begin
			sense_r <= sense_nxt;
			pinfn_r <= pinfn_nxt;
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
			osc1_r <= osc_clk;
			osc2_r <= osc1_r;
			osc3_r <= osc2_r;
			aux1_r <= aux32k_clk;
			aux2_r <= aux1_r;
			aux3_r <= aux2_r;
			ss1_r <= ss_pin_n;
			ss2_r <= ss1_r;
			bcnt_r <= bcnt_nxt;
			btog_r <= btog_nxt;
			otog_r <= otog_nxt;
			atog_r <= atog_nxt;
			beep_pin <= beep_nxt;
			beep_pin_alt <= beep_alt_nxt;
			aux_clock_pin <= aux_nxt;
			aux_clock_pin_alt <= aux_alt_nxt;
			spi_ss_n <= pinfn_r[MSCR_SS_SRC] ? pinfn_r[MSCR_SS_SOFT] : ss2_r;
			// one request line per pin, so each line keeps its own vector
			ext_irq_req <= pin_evt;
			nmi_req <= evt[MSCR_IRQ_NMI];
			irq <= |(stat_nxt & mask_nxt);
			// ready on the setup cycle so the access phase completes at once
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & ~hit;
			if (rd_acc && !penable) begin
				case (paddr)
					MSCR_OFS_SENSE: prdata <= {24'h000000, sense_r & MSCR_RSVD_MASK};
					MSCR_OFS_PINFN: prdata <= {24'h000000, pinfn_r & MSCR_RSVD_MASK};
					MSCR_OFS_IRQ_STAT: prdata <= {29'h00000000, stat_r};
					MSCR_OFS_IRQ_MASK: prdata <= {29'h00000000, mask_r};
					default: prdata <= 32'h00000000;
				endcase
			end
		end
	end

	// ==========================================================
	// checks
	property p_g1_lock;
		@(posedge pclk) disable iff (!presetn) pce && !lvl3 |=> $stable(sense_r[MSCR_G1_HI:MSCR_G1_LO]);
	endproperty : p_g1_lock
	a_g1_lock: assert property (p_g1_lock)
		else $error("group one sense changed outside level 3");
	property p_g2_lock;
		@(posedge pclk) disable iff (!presetn) pce && !lvl3 |=> $stable(sense_r[MSCR_G2_HI:MSCR_G2_LO]);
	endproperty : p_g2_lock
	a_g2_lock: assert property (p_g2_lock)
		else $error("group two sense changed outside level 3");
	// read data is only fresh on a read access; writes leave prdata as it was
	property p_rsvd;
		@(posedge pclk) disable iff (!presetn)
			(sense_r & ~MSCR_RSVD_MASK) == 8'h00 && (pinfn_r & ~MSCR_RSVD_MASK) == 8'h00 &&
			prdata[31:8] == 24'h000000 &&
			(!(pready && !pwrite && (paddr == MSCR_OFS_SENSE || paddr == MSCR_OFS_PINFN)) ||
			(prdata[7:0] & ~MSCR_RSVD_MASK) == 8'h00);
	endproperty : p_rsvd
	a_rsvd: assert property (p_rsvd)
		else $error("reserved bits nonzero");
	property p_nmi_edge;
		@(posedge pclk) disable iff (!presetn) sense_r[MSCR_NMI_EN] |=> $stable(sense_r[MSCR_NMI_EDGE]);
	endproperty : p_nmi_edge
	a_nmi_edge: assert property (p_nmi_edge)
		else $error("nmi edge changed while enabled");
	property p_nmi_gate;
		@(posedge pclk) disable iff (!presetn) pce && !sense_r[MSCR_NMI_EN] |=> !nmi_req;
	endproperty : p_nmi_gate
	a_nmi_gate: assert property (p_nmi_gate)
		else $error("nmi raised while disabled");
	property p_halt;
		@(posedge pclk) disable iff (!presetn) pce && halt_mode |=> !beep_pin_alt && !aux_clock_pin_alt;
	endproperty : p_halt
	a_halt: assert property (p_halt)
		else $error("clock out active in halt");
	property p_ss;
		@(posedge pclk) disable iff (!presetn)
			pce && pinfn_r[MSCR_SS_SRC] |=> spi_ss_n == $past(pinfn_r[MSCR_SS_SOFT]);
	endproperty : p_ss
	a_ss: assert property (p_ss)
		else $error("soft slave select not used");
	property p_aux;
		@(posedge pclk) disable iff (!presetn) pce && !pinfn_r[MSCR_AUX_CO] |=> !aux_clock_pin_alt;
	endproperty : p_aux
	a_aux: assert property (p_aux)
		else $error("aux clock out without enable");
	c_nmi: cover property (@(posedge pclk) disable iff (!presetn) nmi_req);
	c_beep: cover property (@(posedge pclk) disable iff (!presetn) beep_pin_alt && beep_pin);
	c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq);

endmodule : mscr_top

`default_nettype wire

// file: rtl/mscr_pkg.sv
// mscr_pkg: constants and types shared by the misc control register bank
// assumes: 8-bit registers placed in the low bits of 32-bit apb words
`default_nettype none

package mscr_pkg;

	// ==========================================================
	// register map
	localparam logic [7:0] MSCR_OFS_SENSE = 8'h20;
	localparam logic [7:0] MSCR_OFS_PINFN = 8'h40;
	localparam logic [7:0] MSCR_OFS_IRQ_STAT = 8'h60;
	localparam logic [7:0] MSCR_OFS_IRQ_MASK = 8'h64;
	localparam logic [7:0] MSCR_RST_SENSE = 8'h00;
	localparam logic [7:0] MSCR_RST_PINFN = 8'h00;

	// ==========================================================
	// field positions
	localparam int MSCR_G1_HI = 7;
	localparam int MSCR_G1_LO = 6;
	localparam int MSCR_G2_HI = 5;
	localparam int MSCR_G2_LO = 4;
	localparam int MSCR_NMI_EDGE = 1;
	localparam int MSCR_NMI_EN = 0;
	localparam int MSCR_AUX_CO = 7;
	localparam int MSCR_MAIN_CO = 6;
	localparam int MSCR_BEEP_HI = 5;
	localparam int MSCR_BEEP_LO = 4;
	localparam int MSCR_SS_SRC = 1;
	localparam int MSCR_SS_SOFT = 0;
	localparam logic [7:0] MSCR_RSVD_MASK = 8'hf3;
	localparam logic [1:0] MSCR_PRIO_LEVEL3 = 2'h3;

	// ==========================================================
	// interrupt status bits: g1 group, g2 group, nmi
	localparam int MSCR_NIRQ = 3;
	localparam int MSCR_IRQ_G1 = 0;
	localparam int MSCR_IRQ_G2 = 1;
	localparam int MSCR_IRQ_NMI = 2;

	// ==========================================================
	// beep dividers: half periods in oscillator cycles at 16 mhz
	localparam logic [13:0] MSCR_HALF_2K = 14'h0fa0;
	localparam logic [13:0] MSCR_HALF_1K = 14'h1f40;
	localparam logic [13:0] MSCR_HALF_500 = 14'h3e80;

	typedef enum logic [1:0] {
		MSCR_SENSE_FALL_LOW = 2'b00,
		MSCR_SENSE_FALL = 2'b01,
		MSCR_SENSE_RISE = 2'b10,
		MSCR_SENSE_BOTH = 2'b11
	} mscr_sense_t;

endpackage : mscr_pkg

`default_nettype wire

// file: rtl/mscr_edge.sv
// mscr_edge: one synchronised pin with sensitivity-selected event detection
// assumes: pin is asynchronous to pclk; sense code from the register bank
`default_nettype none

module mscr_edge (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pce,
	// pin and selection
	input wire logic pin,
	input wire logic [1:0] sense,
	// event
	output logic event_o
);
	import mscr_pkg::*;

	logic s1_r, s2_r, s3_r;
	logic s1_nxt, s2_nxt, s3_nxt;
	logic fall, rise;

	// ==========================================================
	// two-flop synchroniser plus a history flop
	always_comb begin
		s1_nxt = pin;
		s2_nxt = s1_r;
		s3_nxt = s2_r;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= 1'b1;
			s2_r <= 1'b1;
			s3_r <= 1'b1;
		end else if (pce) begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
		end
	end

	// ==========================================================
	// decode; low level keeps firing while the pin stays low
	assign fall = s3_r & ~s2_r;
	assign rise = ~s3_r & s2_r;

	always_comb begin
		case (mscr_sense_t'(sense))
			MSCR_SENSE_FALL_LOW: event_o = ~s2_r;
			MSCR_SENSE_FALL: event_o = fall;
			MSCR_SENSE_RISE: event_o = rise;
			MSCR_SENSE_BOTH: event_o = fall | rise;
			default: event_o = 1'b0;
		endcase
	end

endmodule : mscr_edge

`default_nettype wire

// file: tb/mscr_pins_model.sv
// mscr_pins_model: far side of the register bank: interrupt pins, ss pin, oscillators
// assumes: the bench moves pins through the pin task, just after a pclk edge
`default_nettype none

module mscr_pins_model (
	// clock
	input wire logic pclk,
	// pins
	output logic [4:0] ext_pins,
	output logic nmi_pin,
	output logic ss_pin_n,
	// oscillators, slow against pclk
	output logic osc_clk,
	output logic aux32k_clk
);
	timeunit 1ns;
	timeprecision 1ps;
	int div = 0;

	initial begin
		ext_pins = 5'h1f;
		nmi_pin = 1'b1;
		ss_pin_n = 1'b1;
		osc_clk = 1'b0;
		aux32k_clk = 1'b0;
	end

	// ==========================================================
	// oscillators run free, so they have no idle level
	always @(posedge pclk) begin
		div <= div + 1;
		// osc period is four pclk cycles; the bench relies on that figure
		if (div % 2 == 1) osc_clk <= ~osc_clk;
		if (div % 6 == 5) aux32k_clk <= ~aux32k_clk;
	end

	// index: 0..4 interrupt pins, 5 nmi, 6 slave select
	task automatic pin(input int i, input logic v);
		@(posedge pclk);
		if (i < 5) ext_pins[i] <= v;
		else if (i == 5) nmi_pin <= v;
		else ss_pin_n <= v;
	endtask : pin
endmodule : mscr_pins_model

`default_nettype wire

// file: tb/test_misc_control_registers.sv
// test_misc_control_registers: self-checking bench of the misc control bank
// assumes: mscr_top with apb slave; pins model on the far side
`default_nettype none

module test_misc_control_registers;
	timeunit 1ns;
	timeprecision 1ps;
	import mscr_pkg::*;
	logic pclk = 0, presetn = 0, pce = 1, psel = 0, penable = 0, pwrite = 0, halt_mode = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, e, nmi_pin, ss_pin_n, osc_clk, aux32k_clk, nmi_req, irq, spi_ss_n;
	logic beep_pin, beep_pin_alt, aux_clock_pin, aux_clock_pin_alt;
	logic [1:0] cpu_priority = 2'h3;
	logic [4:0] ext_pins, ext_irq_req, req_seen = 5'h00;
	int fails = 0, compares = 0, nmi_cnt = 0, nb, na;

	always #20 pclk = ~pclk;
	always @(posedge pclk) if (nmi_req === 1'b1) nmi_cnt <= nmi_cnt + 1;
	// only written while a request line is up, so a clear from a task never races it
	always @(posedge pclk) if (ext_irq_req != 5'h00) req_seen <= req_seen | ext_irq_req;

	mscr_pins_model PM (.pclk(pclk), .ext_pins(ext_pins), .nmi_pin(nmi_pin), .ss_pin_n(ss_pin_n),
		.osc_clk(osc_clk), .aux32k_clk(aux32k_clk));

	mscr_top DUT (.pclk(pclk), .presetn(presetn), .pce(pce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cpu_priority(cpu_priority), .halt_mode(halt_mode),
		.ext_irq_porta_low(ext_pins[0]), .ext_irq_porta_high(ext_pins[1]), .ext_irq_portb(ext_pins[2]),
		.ext_irq_portc(ext_pins[3]), .ext_irq_portd(ext_pins[4]), .nmi_pin(nmi_pin),
		.osc_clk(osc_clk), .aux32k_clk(aux32k_clk), .beep_pin(beep_pin), .beep_pin_alt(beep_pin_alt),
		.aux_clock_pin(aux_clock_pin), .aux_clock_pin_alt(aux_clock_pin_alt), .ss_pin_n(ss_pin_n),
		.spi_ss_n(spi_ss_n), .ext_irq_req(ext_irq_req), .nmi_req(nmi_req), .irq(irq));

	// ==========================================================
	// helpers
	task automatic chk(input string n, input logic [31:0] g, input logic [31:0] x);
		compares++;
		if (g !== x) begin
			fails++;
			$display("Error %s expected %h seen %h", n, x, g);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask : cyc

	// one apb transfer; waits for pready at most 50 edges
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) chk("pready", 0, 1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input string n, input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(n, r, x);
	endtask : rd

	task automatic tgl();
		logic pb, pa;
		pb = beep_pin;
		pa = aux_clock_pin;
		nb = 0;
		na = 0;
		repeat (100) begin
			@(posedge pclk);
			if (beep_pin !== pb) nb++;
			if (aux_clock_pin !== pa) na++;
			pb = beep_pin;
			pa = aux_clock_pin;
		end
	endtask : tgl

	// ==========================================================
	// scenarios
	task automatic t_regs();
		rd("sense reset", MSCR_OFS_SENSE, 32'h0);
		rd("pinfn reset", MSCR_OFS_PINFN, 32'h0);
		cpu_priority <= 2'h0;
		apb(1'b1, MSCR_OFS_SENSE, 32'hff);
		rd("sense low prio", MSCR_OFS_SENSE, 32'h03);
		cpu_priority <= 2'h3;
		apb(1'b1, MSCR_OFS_SENSE, 32'hf1);
		rd("edge held", MSCR_OFS_SENSE, 32'hf3);
		apb(1'b1, MSCR_OFS_SENSE, 32'hf0);
		rd("edge held off", MSCR_OFS_SENSE, 32'hf2);
		apb(1'b1, MSCR_OFS_SENSE, 32'h00);
		rd("sense cleared", MSCR_OFS_SENSE, 32'h00);
		apb(1'b1, MSCR_OFS_PINFN, 32'hff);
		rd("pinfn reserved", MSCR_OFS_PINFN, 32'hf3);
		apb(1'b1, 8'h10, 32'h0);
		chk("unmapped err", e, 1);
		rd("mapped read", MSCR_OFS_PINFN, 32'hf3);
		chk("mapped err", e, 0);
		apb(1'b1, MSCR_OFS_PINFN, 32'h0);
	endtask : t_regs

	// each code on a rotating pin of each group; mask toggles with code
	task automatic t_sense();
		int g1, g2;
		logic f;
		for (int c = 0; c < 4; c++) begin
			g1 = (c % 3 == 0) ? 0 : (c % 3 == 1) ? 2 : 4;
			g2 = (c % 2 == 1) ? 3 : 1;
			f = (c != 2);
			apb(1'b1, MSCR_OFS_SENSE, {24'h0, c[1:0], c[1:0], 4'h0});
			apb(1'b1, MSCR_OFS_IRQ_MASK, c[0] ? 32'h7 : 32'h0);
			apb(1'b1, MSCR_OFS_IRQ_STAT, 32'h7);
			req_seen = 5'h00;
			PM.pin(g1, 1'b0);
			PM.pin(g2, 1'b0);
			cyc(8);
			rd("status fall", MSCR_OFS_IRQ_STAT, {30'h0, f, f});
			chk("ext req", req_seen, f ? (32'h1 << g1) | (32'h1 << g2) : 32'h0);
			chk("irq", irq, f & c[0]);
			apb(1'b1, MSCR_OFS_IRQ_STAT, 32'h7);
			cyc(3);
			rd("status level", MSCR_OFS_IRQ_STAT, {30'h0, c == 0, c == 0});
			PM.pin(g1, 1'b1);
			PM.pin(g2, 1'b1);
			cyc(8);
			rd("status rise", MSCR_OFS_IRQ_STAT, {30'h0, c != 1, c != 1});
		end
		apb(1'b1, MSCR_OFS_IRQ_STAT, 32'h7);
		rd("status clear", MSCR_OFS_IRQ_STAT, 32'h0);
		chk("irq off", irq, 0);
	endtask : t_sense

	task automatic t_nmi();
		apb(1'b1, MSCR_OFS_SENSE, 32'h30);
		apb(1'b1, MSCR_OFS_IRQ_MASK, 32'h4);
		apb(1'b1, MSCR_OFS_IRQ_STAT, 32'h7);
		PM.pin(5, 1'b0);
		cyc(8);
		rd("nmi disabled", MSCR_OFS_IRQ_STAT, 32'h0);
		PM.pin(5, 1'b1);
		cyc(8);
		apb(1'b1, MSCR_OFS_SENSE, 32'h31);
		nmi_cnt = 0;
		PM.pin(5, 1'b0);
		cyc(8);
		rd("nmi fall", MSCR_OFS_IRQ_STAT, 32'h4);
		chk("nmi once", nmi_cnt, 1);
		chk("nmi irq", irq, 1);
		apb(1'b1, MSCR_OFS_IRQ_STAT, 32'h4);
		PM.pin(5, 1'b1);
		cyc(8);
		rd("nmi rise ignored", MSCR_OFS_IRQ_STAT, 32'h0);
		apb(1'b1, MSCR_OFS_SENSE, 32'h30);
		apb(1'b1, MSCR_OFS_SENSE, 32'h32);
		apb(1'b1, MSCR_OFS_SENSE, 32'h33);
		apb(1'b1, MSCR_OFS_IRQ_STAT, 32'h7);
		PM.pin(5, 1'b0);
		cyc(8);
		rd("nmi fall ignored", MSCR_OFS_IRQ_STAT, 32'h0);
		PM.pin(5, 1'b1);
		cyc(8);
		rd("nmi rise", MSCR_OFS_IRQ_STAT, 32'h4);
	endtask : t_nmi

	task automatic t_pins();
		logic [7:0] v[6] = '{8'h00, 8'h40, 8'h10, 8'h20, 8'h30, 8'h70};
		logic pb;
		int n;
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, MSCR_OFS_PINFN, {24'h0, v[i]});
			cyc(3);
			chk("beep alt", beep_pin_alt, i != 0);
			chk("aux alt", aux_clock_pin_alt, 0);
		end
		apb(1'b1, MSCR_OFS_PINFN, 32'hc0);
		cyc(3);
		chk("aux alt on", aux_clock_pin_alt, 1);
		tgl();
		chk("beep runs", nb > 4, 1);
		chk("aux runs", na > 4, 1);
		halt_mode <= 1'b1;
		cyc(4);
		tgl();
		chk("beep halted", nb, 0);
		chk("aux halted", na, 0);
		halt_mode <= 1'b0;
		cyc(4);
		pce <= 1'b0;
		cyc(1);
		tgl();
		chk("beep frozen", nb, 0);
		chk("aux frozen", na, 0);
		pce <= 1'b1;
		apb(1'b1, MSCR_OFS_PINFN, 32'h10);
		cyc(3);
		// second gap is toggle to toggle of the beep divider alone
		for (int k = 0; k < 2; k++) begin
			pb = beep_pin;
			n = 0;
			while (beep_pin === pb && n < 40000) begin
				@(posedge pclk);
				n++;
			end
		end
		chk("beep 2k gap", n, MSCR_HALF_2K * 4);
	endtask : t_pins

	task automatic t_ss();
		apb(1'b1, MSCR_OFS_PINFN, 32'h0);
		PM.pin(6, 1'b0);
		cyc(5);
		chk("ss from pin", spi_ss_n, 0);
		PM.pin(6, 1'b1);
		cyc(5);
		chk("ss pin high", spi_ss_n, 1);
		apb(1'b1, MSCR_OFS_PINFN, 32'h2);
		cyc(5);
		chk("ss soft 0", spi_ss_n, 0);
		apb(1'b1, MSCR_OFS_PINFN, 32'h3);
		PM.pin(6, 1'b0);
		cyc(5);
		chk("ss soft 1", spi_ss_n, 1);
		presetn <= 1'b0;
		cyc(2);
		presetn <= 1'b1;
		rd("sense after reset", MSCR_OFS_SENSE, 32'h0);
		rd("pinfn after reset", MSCR_OFS_PINFN, 32'h0);
	endtask : t_ss

	// ==========================================================
	// run control
	task automatic complete_run();
		if (fails == 0 && compares > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : complete_run

	// whole run needs under forty thousand cycles, mostly the beep gap
	initial begin
		repeat (100000) @(posedge pclk);
		fails++;
		complete_run();
	end

	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_regs();
		t_sense();
		t_nmi();
		t_pins();
		t_ss();
		complete_run();
	end
endmodule : test_misc_control_registers

`default_nettype wire
